// file: bench/i2c_master_model.sv
// Two-wire bus master model standing in for the housekeeping computer
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_o
);
    // Bus idles high; the clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    // One bit time of 16 clocks; data is set well before the rise
    task automatic clk_bit(input logic b, output logic r);
        sda_o = b;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        r = sda_i;
        tick(4);
        scl_o = 1'b0;
        tick(4);
    endtask : clk_bit

    // Only the master opens and closes a frame
    task automatic start_bit();
        sda_o = 1'b1;
        scl_o = 1'b1;
        tick(8);
        sda_o = 1'b0;
        tick(8);
        scl_o = 1'b0;
        tick(4);
    endtask : start_bit

    task automatic stop_bit();
        sda_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        sda_o = 1'b1;
        tick(8);
    endtask : stop_bit

    // Released line during the ack slot lets the slave answer
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask : put_byte

    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(nack, r);
    endtask : get_byte
endmodule : i2c_master_model
`default_nettype wire

// file: bench/tb_battery_telemetry_poller.sv
// Self-checking bench for the battery converter slave
`timescale 1ns/1ps
`default_nettype none
`include "batt_consts.svh"
module tb_battery_telemetry_poller;
    // Short stall limit keeps the run brief; above one SCL half period
    localparam int STALL = 200;
    typedef struct packed {
        logic [2:0] ch;
        logic [11:0] val;
    } row_s;
    // One row per channel: boundary and mixed results
    row_s rows [8] = '{'{3'h0, 12'h000}, '{3'h1, 12'hfff}, '{3'h2, 12'h5a5},
        '{3'h3, 12'ha5a}, '{3'h4, 12'h801}, '{3'h5, 12'h7fe}, '{3'h6, 12'h123},
        '{3'h7, 12'hedc}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wire logic scl_w;
    wire logic m_sda;
    wire logic sda_w;
    logic sda_o;
    logic sda_oe_o;
    logic [`BTP_NUM_CH*`BTP_RESULT_W-1:0] sample_i;
    logic [2:0] channel_o;
    logic request_o;
    logic pwr;
    logic refp;
    logic se;
    int error_cnt = 0;
    int cmp_count = 0;
    int req_cnt = 0;

    always #5 clk_i = ~clk_i;

    // Pull-up wire: either party may pull it low
    assign sda_w = m_sda & ~sda_oe_o;

    always_comb begin
        for (int n = 0; n < 8; n++) begin
            sample_i[12*n +: 12] = rows[n].val;
        end
    end

    always @(posedge clk_i) begin
        if (request_o === 1'b1) begin
            req_cnt <= req_cnt + 1;
        end
    end

    i2c_master_model mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_o(m_sda));

    battery_telemetry_poller #(.STALL_CYCLES(STALL), .FIFO_DEPTH(8)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .sample_i(sample_i), .channel_o(channel_o),
        .request_o(request_o), .converter_power_bit_o(pwr),
        .reference_power_bit_o(refp), .single_ended_o(se));

    task automatic chk_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    task automatic test_done();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Power on, reference on, single-ended, channel named
    function automatic logic [7:0] cmd_byte(input logic [2:0] ch);
        return {1'b1, ch, 1'b1, 1'b1, 2'b00};
    endfunction : cmd_byte

    // Counts the address ack plus every command ack; wraps after channel 7
    task automatic send_cmds(input int n, input int ch0, output int acks);
        logic a;
        mst.start_bit();
        mst.put_byte({`BTP_SLAVE_ADDR, 1'b0}, a);
        acks = int'(a);
        for (int k = 0; k < n; k++) begin
            mst.put_byte(cmd_byte(3'((ch0 + k) % 8)), a);
            acks += int'(a);
        end
        mst.stop_bit();
    endtask : send_cmds

    // High byte first, last low byte not acked
    task automatic read_chk(input int n, input int ch0, input logic empty);
        logic a;
        logic [7:0] hi;
        logic [7:0] lo;
        mst.start_bit();
        mst.put_byte({`BTP_SLAVE_ADDR, 1'b1}, a);
        chk_val("read address ack", 12'h001, {11'h0, a});
        for (int k = 0; k < n; k++) begin
            mst.get_byte(1'b0, hi);
            mst.get_byte(k == n - 1, lo);
            chk_val("result", empty ? 12'h000 : rows[(ch0 + k) % 8].val, {hi[3:0], lo});
            chk_val("high pad", 12'h000, {8'h00, hi[7:4]});
        end
        mst.stop_bit();
    endtask : read_chk

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end

    initial begin
        int acks;
        logic a;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        chk_val("reset outputs", 12'h000,
            {3'h0, sda_o, sda_oe_o, request_o, pwr, refp, se, channel_o});
        // Presence test first; no polling if absent
        send_cmds(0, 0, acks);
        chk_val("presence ack", 12'h001, 12'(acks));
        if (acks == 1) begin
            // Ascending sweep, one request per channel; a round is far under 15 s
            for (int i = 0; i < 8; i++) begin
                send_cmds(1, i, acks);
                chk_val("command acks", 12'h002, 12'(acks));
                chk_val("request count", 12'(i + 2 - 1), 12'(req_cnt));
                chk_val("channel", {9'h0, rows[i].ch}, {9'h0, channel_o});
                chk_val("command bits", 12'h007, {9'h0, pwr, refp, se});
                read_chk(1, i, 1'b0);
            end
        end
        // Foreign address is ignored
        mst.start_bit();
        mst.put_byte({7'h49, 1'b0}, a);
        mst.stop_bit();
        chk_val("foreign ack", 12'h000, {11'h0, a});
        chk_val("foreign requests", 12'h008, 12'(req_cnt));
        // Nine commands: the ninth meets a full queue and is refused
        send_cmds(9, 0, acks);
        chk_val("full acks", 12'h009, 12'(acks));
        chk_val("full requests", 12'h010, 12'(req_cnt));
        read_chk(8, 0, 1'b0);
        read_chk(1, 0, 1'b1);
        // Master stalls mid-read; the slave must let go of the wire
        mst.start_bit();
        mst.put_byte({`BTP_SLAVE_ADDR, 1'b1}, a);
        mst.tick(4);
        chk_val("drives zero msb", 12'h001, {11'h0, sda_oe_o});
        mst.tick(STALL + 20);
        chk_val("stall release", 12'h000, {11'h0, sda_oe_o});
        mst.stop_bit();
        // Reset in mid-run empties the queue
        send_cmds(2, 3, acks);
        chk_val("acks before reset", 12'h003, 12'(acks));
        chk_val("requests before reset", 12'h012, 12'(req_cnt));
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        chk_val("channel after reset", 12'h000, {9'h0, channel_o});
        read_chk(1, 0, 1'b1);
        test_done();
    end
endmodule : tb_battery_telemetry_poller
`default_nettype wire

// file: hw/batt_consts.svh
// Constants for the battery telemetry converter slave
`ifndef BATT_CONSTS_SVH
`define BATT_CONSTS_SVH

`define BTP_SLAVE_ADDR 7'h48
`define BTP_NUM_CH 8
`define BTP_RESULT_W 12
// Command byte layout
`define BTP_SE_BIT 7
`define BTP_CH_MSB 6
`define BTP_CH_LSB 4
`define BTP_REF_BIT 3
`define BTP_PWR_BIT 2
// Timing
`define BTP_CLK_PERIOD_NS 10
`define BTP_SCL_FREQ_HZ 10000
`define BTP_SCL_PERIOD_NS (1000000000 / `BTP_SCL_FREQ_HZ)
`define BTP_STALL_CYCLES ((2 * `BTP_SCL_PERIOD_NS) / `BTP_CLK_PERIOD_NS)
`define BTP_FIFO_DEPTH 8

`endif

// file: hw/batt_pkg.sv
// Types for the battery telemetry converter slave
`default_nettype none
package batt_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_CMD = 7'h08,
        ST_CMD_ACK = 7'h10,
        ST_TX = 7'h20,
        ST_TX_ACK = 7'h40
    } link_state_e;
endpackage : batt_pkg
`default_nettype wire

// file: hw/battery_telemetry_poller.sv
// Battery board converter: two-wire slave returning 12-bit channel results
`timescale 1ns/1ps
`default_nettype none
`include "batt_consts.svh"
module battery_telemetry_poller #(
    parameter int STALL_CYCLES = `BTP_STALL_CYCLES,
    parameter int FIFO_DEPTH = `BTP_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [`BTP_NUM_CH*`BTP_RESULT_W-1:0] sample_i,
    output logic [2:0] channel_o,
    output logic request_o,
    output logic converter_power_bit_o,
    output logic reference_power_bit_o,
    output logic single_ended_o
);
    localparam int RW = `BTP_RESULT_W;
    localparam int TW = $clog2(STALL_CYCLES + 1);

    // Unpack converter results, one word per channel
    logic [RW-1:0] sample_arr [`BTP_NUM_CH];
    for (genvar g = 0; g < `BTP_NUM_CH; g++) begin : g_ch
        // Ch0 current, 1-3 stacked pair voltages, 4-7 temperatures
        assign sample_arr[g] = sample_i[g*RW +: RW];
    end

    // Two-flop synchronisers plus one stage for edge finding
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, timeout;
    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;
    // Bar a stall timeout release, our own drive changes only while the clock is low, so no false start/stop
    assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

    batt_pkg::link_state_e state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
    logic rw_reg, rw_next, byte_sel_reg, byte_sel_next, mack_reg, mack_next;
    logic oe_reg, oe_next;
    logic [TW-1:0] idle_cnt_reg, idle_cnt_next;
    logic [2:0] ch_reg, ch_next;
    logic req_reg, req_next, pwr_reg, pwr_next, refp_reg, refp_next, se_reg, se_next;
    logic fifo_push, fifo_pop, fifo_in_ready, fifo_out_valid;
    logic [RW-1:0] fifo_head, head_word;

    // An empty FIFO reads back as zero rather than stale data
    assign head_word = fifo_out_valid ? fifo_head : '0;
    assign timeout = (idle_cnt_reg == TW'(STALL_CYCLES));

    // Link state machine, slave side only
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        rw_next = rw_reg;
        byte_sel_next = byte_sel_reg;
        mack_next = mack_reg;
        oe_next = oe_reg;
        ch_next = ch_reg;
        pwr_next = pwr_reg;
        refp_next = refp_reg;
        se_next = se_reg;
        req_next = 1'b0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        // Stuck master: give the bus back after two missing clock periods
        idle_cnt_next = (state_reg == batt_pkg::ST_IDLE || scl_rise || scl_fall) ? '0
                        : (timeout ? idle_cnt_reg : idle_cnt_reg + 1'b1);
        if (start_det) begin
            state_next = batt_pkg::ST_ADDR;
            bit_next = '0;
            oe_next = 1'b0;
        end else if (stop_det || timeout) begin
            state_next = batt_pkg::ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                batt_pkg::ST_IDLE: begin
                    oe_next = 1'b0;
                end
                batt_pkg::ST_ADDR, batt_pkg::ST_CMD: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s2};
                        bit_next = bit_reg + 1'b1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        bit_next = '0;
                        if (state_reg == batt_pkg::ST_ADDR) begin
                            if (shift_reg[7:1] == `BTP_SLAVE_ADDR) begin
                                state_next = batt_pkg::ST_ADDR_ACK;
                                rw_next = shift_reg[0];
                                oe_next = 1'b1;
                            end else begin
                                state_next = batt_pkg::ST_IDLE;
                            end
                        end else if (fifo_in_ready) begin
                            // Convert the named channel now and queue it
                            state_next = batt_pkg::ST_CMD_ACK;
                            oe_next = 1'b1;
                            fifo_push = 1'b1;
                            req_next = 1'b1;
                            ch_next = shift_reg[`BTP_CH_MSB:`BTP_CH_LSB];
                            pwr_next = shift_reg[`BTP_PWR_BIT];
                            refp_next = shift_reg[`BTP_REF_BIT];
                            se_next = shift_reg[`BTP_SE_BIT];
                        end else begin
                            // Full FIFO: leave the byte unacknowledged
                            state_next = batt_pkg::ST_IDLE;
                        end
                    end
                end
                batt_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            // High byte first: four zero bits then result [11:8]
                            state_next = batt_pkg::ST_TX;
                            byte_sel_next = 1'b0;
                            oe_next = 1'b1;
                            tx_next = {4'h0, head_word[RW-1:8]} << 1;
                            bit_next = 4'h1;
                        end else begin
                            state_next = batt_pkg::ST_CMD;
                            oe_next = 1'b0;
                        end
                    end
                end
                batt_pkg::ST_CMD_ACK: begin
                    if (scl_fall) begin
                        state_next = batt_pkg::ST_CMD;
                        oe_next = 1'b0;
                    end
                end
                batt_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_reg == 4'h8) begin
                            state_next = batt_pkg::ST_TX_ACK;
                            oe_next = 1'b0;
                            bit_next = '0;
                        end else begin
                            oe_next = !tx_reg[7];
                            tx_next = {tx_reg[6:0], 1'b0};
                            bit_next = bit_reg + 1'b1;
                        end
                    end
                end
                batt_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        mack_next = !sda_s2;
                        // Low byte finished: the word is consumed
                        fifo_pop = byte_sel_reg;
                    end else if (scl_fall) begin
                        if (mack_reg) begin
                            state_next = batt_pkg::ST_TX;
                            byte_sel_next = !byte_sel_reg;
                            bit_next = 4'h1;
                            if (byte_sel_reg) begin
                                oe_next = 1'b1;
                                tx_next = {4'h0, head_word[RW-1:8]} << 1;
                            end else begin
                                oe_next = !head_word[7];
                                tx_next = {head_word[6:0], 1'b0};
                            end
                        end else begin
                            state_next = batt_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = batt_pkg::ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= batt_pkg::ST_IDLE;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            byte_sel_reg <= 1'b0;
            mack_reg <= 1'b0;
            oe_reg <= 1'b0;
            idle_cnt_reg <= '0;
            ch_reg <= 3'h0;
            req_reg <= 1'b0;
            pwr_reg <= 1'b0;
            refp_reg <= 1'b0;
            se_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            rw_reg <= rw_next;
            byte_sel_reg <= byte_sel_next;
            mack_reg <= mack_next;
            oe_reg <= oe_next;
            idle_cnt_reg <= idle_cnt_next;
            ch_reg <= ch_next;
            req_reg <= req_next;
            pwr_reg <= pwr_next;
            refp_reg <= refp_next;
            se_reg <= se_next;
        end
    end

    // Results wait here until the master reads them; full refuses the command
    result_fifo #(
        .WIDTH(RW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(sample_arr[shift_reg[`BTP_CH_MSB:`BTP_CH_LSB]]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_head)
    );

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign channel_o = ch_reg;
    assign request_o = req_reg;
    assign converter_power_bit_o = pwr_reg;
    assign reference_power_bit_o = refp_reg;
    assign single_ended_o = se_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_addr_byte_done;
        state_reg == batt_pkg::ST_ADDR && scl_fall && bit_reg == 4'h8
            && !start_det && !stop_det && !timeout;
    endsequence
    sequence s_addr_match;
        s_addr_byte_done ##0 shift_reg[7:1] == `BTP_SLAVE_ADDR;
    endsequence

    property p_slave_quiet;
        state_reg == batt_pkg::ST_IDLE |-> !sda_oe_o;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("Driving bus while idle");

    property p_addr_ack;
        s_addr_match |=> state_reg == batt_pkg::ST_ADDR_ACK && sda_oe_o;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Own address not acked");

    property p_addr_nack;
        s_addr_byte_done ##0 shift_reg[7:1] != `BTP_SLAVE_ADDR
            |=> state_reg == batt_pkg::ST_IDLE && !sda_oe_o;
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("Foreign address acked");

    property p_channel_latched;
        fifo_push |=> request_o && channel_o == $past(shift_reg[6:4]);
    endproperty
    a_channel_latched: assert property (p_channel_latched) else $error("Wrong channel");

    property p_high_nibble_zero;
        state_reg == batt_pkg::ST_ADDR_ACK && rw_reg && scl_fall && !start_det
            && !stop_det && !timeout |=> sda_oe_o && tx_reg[7:5] == 3'h0;
    endproperty
    a_high_nibble_zero: assert property (p_high_nibble_zero) else $error("High nibble set");

    property p_ref_follows_cmd;
        fifo_push |=> reference_power_bit_o == $past(shift_reg[3])
            && converter_power_bit_o == $past(shift_reg[2]);
    endproperty
    a_ref_follows_cmd: assert property (p_ref_follows_cmd) else $error("Power bits lost");

    property p_ack_held;
        state_reg == batt_pkg::ST_CMD_ACK && !scl_fall && !start_det && !stop_det && !timeout
            |=> sda_oe_o && state_reg == batt_pkg::ST_CMD_ACK;
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("Ack released early");

    property p_full_refused;
        state_reg == batt_pkg::ST_CMD && scl_fall && bit_reg == 4'h8 && !fifo_in_ready
            && !start_det && !stop_det && !timeout
            |=> state_reg == batt_pkg::ST_IDLE && !sda_oe_o && !request_o;
    endproperty
    a_full_refused: assert property (p_full_refused) else $error("Full FIFO acked");
endmodule : battery_telemetry_poller
`default_nettype wire

// file: hw/result_fifo.sv
// Small flip-flop FIFO holding conversion results
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic do_wr, do_rd;

    // Pointer and count update; full and empty come from the count
    always_comb begin
        do_wr = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
        do_rd = out_ready_i && (cnt_reg != '0);
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (do_wr) begin
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (do_rd) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage needs no reset; reads are gated by the count
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rd_reg];
endmodule : result_fifo
`default_nettype wire
